//--- design/pcct_timer.sv
// card cycle timer: apb registers and setup / strobe / hold phase sequencer
`timescale 1ns/1ps
`include "pcct_defines.svh"

module pcct_timer (
  // clock and reset
  input  wire logic             I_SYS_CLK,
  input  wire logic             I_RESET_N,
  // apb slave
  input  wire pcct_pkg::pcct_apb_req_t I_APB,
  output      pcct_pkg::pcct_apb_rsp_t O_APB,
  // card side
  output      pcct_pkg::pcct_card_t    O_CARD,
  output      logic             O_BUSY
);
  import pcct_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pcct_state_t s_q;
  pcct_state_t s_d;

  localparam logic [3:0] TICK_LAST = 4'(`PCCT_TICK_CYC - 1);

  // ----------------------------------------------------------------
  // phase length lookup
  // ----------------------------------------------------------------
  function automatic logic [4:0] setup_len(input pcct_cfg_t c);
    logic [4:0] n;
    n = `PCCT_SU_IO;
    if (c.is_io) begin
      n = `PCCT_SU_IO;
    end else if (c.ws[1]) begin
      n = `PCCT_SU_MEM_HI;
    end else begin
      n = `PCCT_SU_MEM_LO;
    end
    return n;
  endfunction

  // 8-bit strobe intervals
  function automatic logic [4:0] strobe8_len(input pcct_cfg_t c);
    logic [4:0] n;
    n = `PCCT_S8_BASE;
    if (c.is_io) begin
      // i/o cycles look at the single wait bit only
      if (c.ws[0]) begin
        n = `PCCT_S8_WAIT;
      end else if (c.zws) begin
        n = `PCCT_S8_ZW;
      end else begin
        n = `PCCT_S8_BASE;
      end
    end else begin
      if (c.ws != 2'h0) begin
        n = `PCCT_S8_WAIT;
      end else if (c.zws) begin
        n = `PCCT_S8_ZW;
      end else begin
        n = `PCCT_S8_BASE;
      end
    end
    return n;
  endfunction

  // 16-bit strobe intervals
  function automatic logic [4:0] strobe16_len(input pcct_cfg_t c);
    logic [4:0] n;
    n = `PCCT_S16_IO;
    if (c.is_io) begin
      // zero-wait has no meaning on 16-bit i/o
      n = c.ws[0] ? `PCCT_S16_IO_WAIT : `PCCT_S16_IO;
    end else begin
      case (c.ws)
        2'h0: begin
          n = c.zws ? `PCCT_S16_MEM_ZW : `PCCT_S16_MEM_00;
        end
        2'h1: begin
          n = `PCCT_S16_MEM_01;
        end
        2'h2: begin
          n = `PCCT_S16_MEM_10;
        end
        default: begin
          n = `PCCT_S16_MEM_11;
        end
      endcase
    end
    return n;
  endfunction

  function automatic logic [4:0] strobe_len(input pcct_cfg_t c);
    logic [4:0] n;
    n = c.wide16 ? strobe16_len(c) : strobe8_len(c);
    return n;
  endfunction

  function automatic logic [4:0] hold_len(input pcct_cfg_t c);
    logic [4:0] n;
    n = `PCCT_HOLD_IO;
    if (c.is_io) begin
      n = `PCCT_HOLD_IO;
    end else if (c.ws[1]) begin
      n = `PCCT_HOLD_MEM_HI;
    end else begin
      n = `PCCT_HOLD_MEM_LO;
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic apb_setup;
  logic apb_wr;
  logic hit_ctrl;
  logic hit_addr;
  logic hit_stat;
  logic go;
  logic tick;
  logic last;

  always_comb begin
    apb_setup = I_APB.psel & ~I_APB.penable;
    apb_wr    = I_APB.psel & I_APB.penable & I_APB.pwrite;
    hit_ctrl  = (I_APB.paddr == `PCCT_OFF_CTRL);
    hit_addr  = (I_APB.paddr == `PCCT_OFF_ADDR);
    hit_stat  = (I_APB.paddr == `PCCT_OFF_STAT);
    go        = apb_wr & hit_ctrl & I_APB.pwdata[`PCCT_CTRL_GO_BIT];
    // one host bus period elapses every TICK_CYC system clocks
    tick      = (s_q.presc == TICK_LAST);
    last      = tick & (s_q.cnt == 5'h01);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // read data is latched in the setup cycle so prdata comes from a flop
    if (apb_setup) begin
      s_d.prdata  = 32'h0;
      s_d.pslverr = 1'b0;
      if (I_APB.pwrite) begin
        s_d.pslverr = ~(hit_ctrl | hit_addr | hit_stat);
      end else if (hit_ctrl) begin
        s_d.prdata[6:0] = s_q.cfg;
      end else if (hit_addr) begin
        s_d.prdata[25:0] = s_q.addr;
      end else if (hit_stat) begin
        s_d.prdata[`PCCT_STAT_BUSY_BIT] = (s_q.phase != PCCT_IDLE);
        s_d.prdata[`PCCT_STAT_PH_LSB +: 4] = s_q.phase;
        s_d.prdata[`PCCT_STAT_DONE_BIT] = s_q.done;
      end else begin
        s_d.pslverr = 1'b1;
      end
    end

    // register writes
    if (apb_wr & hit_ctrl) begin
      s_d.cfg = I_APB.pwdata[6:0];
    end
    if (apb_wr & hit_addr) begin
      s_d.addr = I_APB.pwdata[25:0];
    end
    // done is write-one-to-clear; the end of a cycle below overrides it
    if (apb_wr & hit_stat & I_APB.pwdata[`PCCT_STAT_DONE_BIT]) begin
      s_d.done = 1'b0;
    end

    // prescaler runs only while a cycle is in flight
    if (s_q.phase == PCCT_IDLE) begin
      s_d.presc = 4'h0;
    end else if (tick) begin
      s_d.presc = 4'h0;
    end else begin
      s_d.presc = s_q.presc + 4'h1;
    end

    // phase sequencer
    case (s_q.phase)
      PCCT_IDLE: begin
        // a start while busy is dropped; only idle accepts one
        if (go) begin
          s_d.cur      = I_APB.pwdata[6:0];
          s_d.cur_addr = s_q.addr;
          s_d.cnt      = setup_len(I_APB.pwdata[6:0]);
          s_d.phase    = PCCT_SETUP;
        end
      end
      PCCT_SETUP: begin
        if (last) begin
          s_d.cnt   = strobe_len(s_q.cur);
          s_d.phase = PCCT_STROBE;
        end else if (tick) begin
          s_d.cnt = s_q.cnt - 5'h01;
        end
      end
      PCCT_STROBE: begin
        if (last) begin
          s_d.cnt   = hold_len(s_q.cur);
          s_d.phase = PCCT_HOLD;
        end else if (tick) begin
          s_d.cnt = s_q.cnt - 5'h01;
        end
      end
      PCCT_HOLD: begin
        if (last) begin
          s_d.cnt   = 5'h00;
          s_d.phase = PCCT_IDLE;
          s_d.done  = 1'b1;
        end else if (tick) begin
          s_d.cnt = s_q.cnt - 5'h01;
        end
      end
      default: begin
        s_d.phase = PCCT_IDLE;
        s_d.cnt   = 5'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      s_q.phase    <= PCCT_IDLE;
      s_q.cfg      <= `PCCT_CTRL_RST;
      s_q.cur      <= `PCCT_CTRL_RST;
      s_q.addr     <= `PCCT_ADDR_RST;
      s_q.cur_addr <= `PCCT_ADDR_RST;
      s_q.presc    <= 4'h0;
      s_q.cnt      <= 5'h00;
      s_q.done     <= 1'b0;
      s_q.prdata   <= 32'h0;
      s_q.pslverr  <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    O_APB.prdata  = s_q.prdata;
    O_APB.pready  = 1'b1;
    O_APB.pslverr = s_q.pslverr;
    O_CARD.addr   = s_q.cur_addr;
    // address stays driven through setup, strobe and hold
    O_CARD.addr_en = (s_q.phase != PCCT_IDLE);
    O_CARD.cmd_n   = (s_q.phase != PCCT_STROBE);
    O_CARD.is_io   = s_q.cur.is_io;
    O_BUSY         = (s_q.phase != PCCT_IDLE);
  end

endmodule // pcct_timer

//--- design/pcct_defines.svh
// constants for the card cycle timer: offsets, fields, resets, phase counts
// Notes on behaviour
// - setup, strobe and hold phases are timed by counting host bus clock periods.
// - phases match legacy timing but are always slightly longer than it.
// - address setup is 3 clocks on I/O, memory 2 or 4 by upper wait bit.
// - 8-bit I/O strobe is 19 clocks, 23 with wait bit, 7 with zero-wait.
// - 8-bit memory strobe is 19 at field 00, 7 with zero-wait, else 23.
// - 16-bit I/O strobe is 7 clocks, 11 with wait bit; zero-wait ignored.
// - 16-bit memory strobe is 9, 13, 17 clocks for wait field 00, 01, 10.
// - 16-bit memory strobe is 23 clocks at field 11, 5 at 00 with zero-wait.
// - address hold is 2 clocks on I/O, memory 2 or 3 by upper wait bit.
`ifndef PCCT_DEFINES_SVH
`define PCCT_DEFINES_SVH

// ----------------------------------------------------------------
// clock conversion
// ----------------------------------------------------------------
`define PCCT_HB_PERIOD_NS   30
`define PCCT_SYS_PERIOD_NS  4
// host period rounded up to system clocks: 8 x 4 ns = 32 ns >= 30 ns
`define PCCT_TICK_CYC       ((`PCCT_HB_PERIOD_NS + `PCCT_SYS_PERIOD_NS - 1) / `PCCT_SYS_PERIOD_NS)

// ----------------------------------------------------------------
// phase lengths in host bus clock periods
// ----------------------------------------------------------------
`define PCCT_SU_IO          5'h03
`define PCCT_SU_MEM_LO      5'h02
`define PCCT_SU_MEM_HI      5'h04
`define PCCT_S8_BASE        5'h13
`define PCCT_S8_WAIT        5'h17
`define PCCT_S8_ZW          5'h07
`define PCCT_S16_IO         5'h07
`define PCCT_S16_IO_WAIT    5'h0b
`define PCCT_S16_MEM_00     5'h09
`define PCCT_S16_MEM_01     5'h0d
`define PCCT_S16_MEM_10     5'h11
`define PCCT_S16_MEM_11     5'h17
`define PCCT_S16_MEM_ZW     5'h05
`define PCCT_HOLD_IO        5'h02
`define PCCT_HOLD_MEM_LO    5'h02
`define PCCT_HOLD_MEM_HI    5'h03
`define PCCT_TS_DEFAULT     2'h1

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PCCT_OFF_CTRL       12'h000
`define PCCT_OFF_ADDR       12'h004
`define PCCT_OFF_STAT       12'h008
`define PCCT_CTRL_IO_BIT    0
`define PCCT_CTRL_W16_BIT   1
`define PCCT_CTRL_WS_LSB    2
`define PCCT_CTRL_ZWS_BIT   4
`define PCCT_CTRL_TS_LSB    5
`define PCCT_CTRL_GO_BIT    31
`define PCCT_STAT_BUSY_BIT  0
`define PCCT_STAT_PH_LSB    1
`define PCCT_STAT_DONE_BIT  8
`define PCCT_CTRL_RST       7'h20
`define PCCT_ADDR_RST       26'h0000000

`endif

//--- design/pcct_pkg.sv
// types shared by the card cycle timer
package pcct_pkg;

  typedef enum logic [3:0] {
    PCCT_IDLE   = 4'b0001,
    PCCT_SETUP  = 4'b0010,
    PCCT_STROBE = 4'b0100,
    PCCT_HOLD   = 4'b1000
  } pcct_phase_t;

  typedef struct packed {
    logic [1:0] ts;
    logic       zws;
    logic [1:0] ws;
    logic       wide16;
    logic       is_io;
  } pcct_cfg_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pcct_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pcct_apb_rsp_t;

  typedef struct packed {
    logic [25:0] addr;
    logic        addr_en;
    logic        cmd_n;
    logic        is_io;
  } pcct_card_t;

  typedef struct packed {
    pcct_phase_t phase;
    pcct_cfg_t   cfg;
    pcct_cfg_t   cur;
    logic [25:0] addr;
    logic [25:0] cur_addr;
    logic [3:0]  presc;
    logic [4:0]  cnt;
    logic        done;
    logic [31:0] prdata;
    logic        pslverr;
  } pcct_state_t;

endpackage

//--- dv/pcct_card_model.sv
// card-side model: measures setup, strobe and hold of each card cycle
`timescale 1ns/1ps
module pcct_card_model (
  // clock and card pins
  input  wire logic             i_clk,
  input  wire pcct_pkg::pcct_card_t i_card,
  // measured phase lengths, system clocks
  output logic [9:0]            o_su,
  output logic [9:0]            o_st,
  output logic [9:0]            o_hd
);
  import pcct_pkg::*;
  logic [9:0] cnt_q = 10'h000;
  logic       ae_q  = 1'b0;
  logic       cn_q  = 1'b1;
  // the card only sees pin levels, so lengths are counted per clock
  always_ff @(posedge i_clk) begin
    cnt_q <= cnt_q + 10'h001;
    if (i_card.addr_en && !ae_q) cnt_q <= 10'h001;
    if (!i_card.cmd_n && cn_q) begin
      o_su  <= cnt_q;
      cnt_q <= 10'h001;
    end
    if (i_card.cmd_n && !cn_q) begin
      o_st  <= cnt_q;
      cnt_q <= 10'h001;
    end
    if (!i_card.addr_en && ae_q) o_hd <= cnt_q;
    ae_q <= i_card.addr_en;
    cn_q <= i_card.cmd_n;
  end
endmodule // pcct_card_model

//--- dv/pcct_timer_chk.sv
// assertions on the card cycle timer ports
`timescale 1ns/1ps
module pcct_timer_chk (
  // clock and reset
  input wire logic                    I_SYS_CLK,
  input wire logic                    I_RESET_N,
  // watched ports
  input wire pcct_pkg::pcct_apb_req_t I_APB,
  input wire pcct_pkg::pcct_apb_rsp_t O_APB,
  input wire pcct_pkg::pcct_card_t    O_CARD,
  input wire logic                    O_BUSY
);
  import pcct_pkg::*;
  logic [9:0] len_q;
  logic       ae_q;
  logic       cn_q;
  logic       go_w;
  // ----------------------------------------------------------------
  // segment length helper
  // ----------------------------------------------------------------
  assign go_w = I_APB.psel && I_APB.penable && I_APB.pwrite && I_APB.paddr == 12'h000
                && I_APB.pwdata[31] && !O_BUSY;
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      len_q <= 10'h000;
      ae_q  <= 1'b0;
      cn_q  <= 1'b1;
    end else begin
      len_q <= (O_CARD.addr_en != ae_q || O_CARD.cmd_n != cn_q) ? 10'h001 : len_q + 10'h001;
      ae_q  <= O_CARD.addr_en;
      cn_q  <= O_CARD.cmd_n;
    end
  end
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESET_N);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_SETUP: assert property ($fell(O_CARD.cmd_n) |-> len_q inside {16, 24, 32})
    else $error("address setup length wrong");
  AST_STROBE: assert property ($rose(O_CARD.cmd_n) |->
    len_q inside {40, 56, 72, 88, 104, 136, 152, 184}) else $error("strobe length wrong");
  AST_HOLD: assert property ($fell(O_CARD.addr_en) |-> len_q inside {16, 24})
    else $error("address hold length wrong");
  AST_WIN: assert property (!O_CARD.cmd_n |-> O_CARD.addr_en && O_BUSY)
    else $error("strobe outside address window");
  AST_BUSY: assert property (O_BUSY == O_CARD.addr_en)
    else $error("busy and address enable disagree");
  AST_GO: assert property (go_w |=> O_BUSY && O_CARD.addr_en && O_CARD.cmd_n)
    else $error("cycle did not start on go");
  AST_START: assert property ($rose(O_CARD.addr_en) |-> $past(go_w))
    else $error("cycle started without go");
  AST_ADDR: assert property (O_CARD.addr_en && $past(O_CARD.addr_en) |->
    $stable(O_CARD.addr)) else $error("card address moved in cycle");
  AST_ERR: assert property (I_APB.psel && I_APB.penable
    && !(I_APB.paddr inside {12'h000, 12'h004, 12'h008}) |-> O_APB.pslverr && O_APB.pready)
    else $error("unmapped access not flagged");
  cover property (go_w);
  cover property ($rose(O_CARD.cmd_n));
  cover property (O_APB.pslverr);
  // status write landing on the cycle-end edge
  cover property (I_APB.psel && I_APB.penable && I_APB.pwrite && I_APB.paddr == 12'h008
    && O_BUSY ##1 !O_BUSY);
endmodule // pcct_timer_chk
bind pcct_timer pcct_timer_chk i_pcct_timer_chk (.I_SYS_CLK(I_SYS_CLK), .I_RESET_N(I_RESET_N),
  .I_APB(I_APB), .O_APB(O_APB), .O_CARD(O_CARD), .O_BUSY(O_BUSY));

//--- dv/test_pcct_timer.sv
// self-checking bench for the card cycle timer
`timescale 1ns/1ps
module test_pcct_timer;
  import pcct_pkg::*;
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  pcct_apb_req_t apb = '0;
  pcct_apb_rsp_t rsp;
  pcct_card_t    card;
  logic          busy;
  logic [9:0]    su, st, hd;
  logic [31:0]   rd;
  logic          err;
  int            num_errors = 0;
  int            cmp_count = 0;
  int            cyc = 0;
  pcct_timer i_pcct_timer (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_APB(apb), .O_APB(rsp),
    .O_CARD(card), .O_BUSY(busy));
  pcct_card_model i_pcct_card_model (.i_clk(clk), .i_card(card), .o_su(su), .o_st(st), .o_hd(hd));
  initial forever #2 clk = ~clk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // 32 cycles of at most 240 clocks each, plus register traffic
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      stop_test;
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    apb <= '0;
  endtask
  // phase lengths in host periods: setup, strobe, hold
  function automatic logic [14:0] exp_len(input logic io, w16, input logic [1:0] ws,
                                          input logic zw);
    logic [4:0] s, c, h;
    s = io ? 5'h03 : (ws[1] ? 5'h04 : 5'h02);
    h = (io || !ws[1]) ? 5'h02 : 5'h03;
    if (!w16) c = (io ? ws[0] : ws != 2'b00) ? 5'h17 : (zw ? 5'h07 : 5'h13);
    else if (io) c = ws[0] ? 5'h0b : 5'h07;
    else if (ws == 2'b00) c = zw ? 5'h05 : 5'h09;
    else c = (ws == 2'b01) ? 5'h0d : ((ws == 2'b10) ? 5'h11 : 5'h17);
    return {s, c, h};
  endfunction
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [14:0] e;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    apb_xfer(1'b0, 12'h000, 32'h0);
    check("ctrl reset", rd, 32'h00000020);
    apb_xfer(1'b0, 12'h00c, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb_xfer(1'b1, 12'h004, 32'h02a5c3e1);
    apb_xfer(1'b0, 12'h004, 32'h0);
    check("addr reg", rd, 32'h02a5c3e1);
    for (int k = 0; k < 32; k++) begin
      e = exp_len(k[0], k[1], k[3:2], k[4]);
      apb_xfer(1'b1, 12'h000, {1'b1, 24'h0, 2'b01, k[4:0]});
      // go and new config while busy must not touch the running cycle
      apb_xfer(1'b1, 12'h000, 32'h80000000);
      while (busy !== 1'b0) @(posedge clk);
      repeat (2) @(posedge clk);
      check("setup", {22'h0, su}, {24'h0, e[14:10], 3'h0});
      check("cmd", {22'h0, st}, {24'h0, e[9:5], 3'h0});
      check("hold", {22'h0, hd}, {24'h0, e[4:0], 3'h0});
      check("is_io", {31'h0, card.is_io}, {31'h0, k[0]});
      check("card addr", {6'h0, card.addr}, 32'h02a5c3e1);
      apb_xfer(1'b0, 12'h008, 32'h0);
      check("status", rd & 32'h1ff, 32'h102);
    end
    apb_xfer(1'b1, 12'h008, 32'h100);
    apb_xfer(1'b0, 12'h008, 32'h0);
    check("status cleared", rd & 32'h1ff, 32'h002);
    // i/o cycle under timing set 11, address moved while busy,
    // done clear written on the very edge the cycle ends, so done stays set: 8 x (3 + 19 + 2) = 192 clocks
    apb_xfer(1'b1, 12'h000, 32'h80000061);
    apb_xfer(1'b1, 12'h004, 32'h01234567);
    repeat (186) @(posedge clk);
    apb_xfer(1'b1, 12'h008, 32'h100);
    repeat (2) @(posedge clk);
    check("busy end", {31'h0, busy}, 32'h0);
    check("setup io", {22'h0, su}, 32'h18);
    check("cmd io", {22'h0, st}, 32'h98);
    check("hold io", {22'h0, hd}, 32'h10);
    check("addr kept", {6'h0, card.addr}, 32'h02a5c3e1);
    apb_xfer(1'b0, 12'h008, 32'h0);
    check("done set wins", rd & 32'h1ff, 32'h102);
    apb_xfer(1'b0, 12'h004, 32'h0);
    check("addr new", rd, 32'h01234567);
    check("mapped err", {31'h0, err}, 32'h0);
    apb_xfer(1'b0, 12'h000, 32'h0);
    check("ctrl ts", rd, 32'h00000061);
    // reset in mid strobe: pins drop at once, registers back to reset values
    apb_xfer(1'b1, 12'h000, 32'h80000000);
    repeat (40) @(posedge clk);
    check("mid busy", {31'h0, busy}, 32'h1);
    check("mid cmd", {31'h0, card.cmd_n}, 32'h0);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    check("rst busy", {31'h0, busy}, 32'h0);
    check("rst pins", {30'h0, card.addr_en, card.cmd_n}, 32'h1);
    rst_n <= 1'b1;
    apb_xfer(1'b0, 12'h000, 32'h0);
    check("ctrl rst again", rd, 32'h00000020);
    apb_xfer(1'b0, 12'h008, 32'h0);
    check("status rst", rd & 32'h1ff, 32'h002);
    apb_xfer(1'b0, 12'h004, 32'h0);
    check("addr rst", rd, 32'h0);
    stop_test;
  end
endmodule // test_pcct_timer
